// >>> verilog/rbmc_cmd_decoder.v
// Functional notes
// - Store cmd: offset then bytes, pointer increments
// - Buffer pointer eight bits, wraps past 255
// - Fetch cmd: offset, dummy, then data per byte
// - SPI fetch of n+1 bytes gives n-2
// - UART adds parameter count byte after opcode for idle and transmit
// - Low power only from either idle mode
// - Frame end powers down all but retained
// - Retention bits: data RAM, buffer, instruction RAM
// - Wake to RC idle on select or timer
// - Registers restored if saved and bit0 set
// - Idle byte 0 RC, 1 crystal
// - Reset enters RC idle
// - Opcode C1 enters synthesizer mode
// - Synth passed through from RC idle to transmit
// - Transmit: step code, 16-bit count, MSB first
// - Osc, PLL, PA ramp, send, ramp down, done
// - Time-out event if no done; back to RC idle
// - Time-out is step times count
// - Zero count disables time-out
// - Nonzero count: first of timer or done
// - SPI returns status on every byte except fetch data
// - UART buffer ops carry byte count
// - SPI command ends at select rising edge
`timescale 1ns/1ps
`include "rbmc_defs.vh"
module rbmc_cmd_decoder #(
  parameter STEP0 = `RBMC_STEP0_CYC,
  parameter STEP1 = `RBMC_STEP1_CYC,
  parameter STEP2 = `RBMC_STEP2_CYC,
  parameter STEP3 = `RBMC_STEP3_CYC,
  parameter PHASE = `RBMC_PHASE_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // SPI pins
  input wire spi_sck,
  input wire chip_select_n,
  input wire spi_mosi,
  output reg spi_miso,
  // UART byte stream (already deframed, same clock)
  input wire uart_rx_valid,
  input wire [7:0] uart_rx_data,
  output reg uart_tx_valid,
  output reg [7:0] uart_tx_data,
  input wire uart_tx_ready,
  // Radio side
  input wire packet_sent,
  input wire rtc_wake,
  output reg [2:0] circuit_mode,
  output reg osc_on,
  output reg pll_on,
  output reg pa_on,
  output reg pa_ramp,
  output reg packet_start,
  output reg [2:0] retention_select,
  output reg power_down,
  output reg context_save,
  output reg context_restore,
  output reg transmit_complete_evt,
  output reg timeout_evt
);
  // Input synchronisers
  reg [2:0] sck_s;
  reg [1:0] cs_s;
  reg [1:0] mosi_s;
  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  reg cs_q;
  wire cs_rise = cs_s[1] & ~cs_q;
  wire cs_fall = ~cs_s[1] & cs_q;

  // Byte assembly
  reg [2:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg byte_ok;
  reg [7:0] byte_val;
  reg byte_uart;

  // Command state
  localparam S_OPC = 3'd0;
  localparam S_LEN = 3'd1;
  localparam S_PAR = 3'd2;
  localparam S_DATA = 3'd3;
  localparam S_IGN = 3'd4;
  reg [2:0] st;
  reg [7:0] opcode;
  reg [2:0] par_idx;
  reg [7:0] par0;
  reg [7:0] par1;
  reg [7:0] uart_cnt;
  reg [7:0] ptr;
  reg [2:0] cmd_status;
  reg ctx_saved;
  reg pending_sleep;

  // Transmit sequencer
  localparam T_IDLE = 3'd0;
  localparam T_OSC = 3'd1;
  localparam T_PLL = 3'd2;
  localparam T_RAMP = 3'd3;
  localparam T_SEND = 3'd4;
  localparam T_DOWN = 3'd5;
  reg [2:0] tx_st;
  reg [7:0] phase_cnt;
  reg [7:0] tx_code;
  reg [15:0] tx_count;
  reg tx_start;
  reg timer_stop;
  wire timer_expired;

  // Buffer
  reg mem_we;
  reg [7:0] mem_wa;
  reg [7:0] mem_wd;
  wire [7:0] mem_rd;
  reg fetch_uart_pend;

  function is_idle;
    input [2:0] m;
    begin
      is_idle = (m == `RBMC_MODE_IDLE_RC) || (m == `RBMC_MODE_IDLE_XTAL);
    end
  endfunction

  function [2:0] param_need;
    input [7:0] op;
    begin
      case (op)
        `RBMC_OP_STORE: param_need = 3'd1;
        `RBMC_OP_FETCH: param_need = 3'd1;
        `RBMC_OP_LOWPWR: param_need = 3'd1;
        `RBMC_OP_IDLE: param_need = 3'd1;
        `RBMC_OP_TX: param_need = 3'd3;
        default: param_need = 3'd0;
      endcase
    end
  endfunction

  wire [7:0] status_byte = {circuit_mode, cmd_status, 1'b0, 1'b0};

  rbmc_buffer_mem #(.AW(8), .DW(8)) u_mem (
    .mclk(mclk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(ptr),
    .rd_data(mem_rd)
  );

  rbmc_tx_timer #(.STEP0(STEP0), .STEP1(STEP1), .STEP2(STEP2), .STEP3(STEP3)) u_timer (
    .mclk(mclk),
    .reset(reset),
    .start(tx_start),
    .stop(timer_stop),
    .timeout_step_code(tx_code[1:0]),
    .timeout_step_count(tx_count),
    .expired(timer_expired)
  );

  // SPI shifting, mode 0: sample on rise, shift on fall
  always @(posedge mclk) begin
    if (reset) begin
      sck_s <= 3'b000;
      cs_s <= 2'b11;
      mosi_s <= 2'b00;
      cs_q <= 1'b1;
      bit_cnt <= 3'd0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      spi_miso <= 1'b0;
      byte_ok <= 1'b0;
      byte_val <= 8'h00;
      byte_uart <= 1'b0;
    end else begin
      sck_s <= {sck_s[1:0], spi_sck};
      cs_s <= {cs_s[0], chip_select_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      cs_q <= cs_s[1];
      byte_ok <= 1'b0;
      if (cs_fall) begin
        bit_cnt <= 3'd0;
        shift_out <= status_byte;
        spi_miso <= status_byte[7];
      end else if (!cs_s[1] && sck_rise) begin
        shift_in <= {shift_in[6:0], mosi_s[1]};
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          byte_ok <= 1'b1;
          byte_val <= {shift_in[6:0], mosi_s[1]};
          byte_uart <= 1'b0;
        end
      end else if (!cs_s[1] && sck_fall) begin
        if (bit_cnt == 3'd0) begin
          // Next byte: payload during fetch data phase, else status
          if (st == S_DATA && opcode == `RBMC_OP_FETCH && par_idx == 3'd2) begin
            shift_out <= mem_rd;
            spi_miso <= mem_rd[7];
          end else begin
            shift_out <= status_byte;
            spi_miso <= status_byte[7];
          end
        end else begin
          spi_miso <= shift_out[3'd7 - bit_cnt];
        end
      end else if (uart_rx_valid && cs_s[1]) begin
        byte_ok <= 1'b1;
        byte_val <= uart_rx_data;
        byte_uart <= 1'b1;
      end
    end
  end

  // Command decoding and modes
  always @(posedge mclk) begin
    if (reset) begin
      st <= S_OPC;
      opcode <= 8'h00;
      par_idx <= 3'd0;
      par0 <= 8'h00;
      par1 <= 8'h00;
      uart_cnt <= 8'h00;
      ptr <= 8'h00;
      cmd_status <= `RBMC_CST_OK;
      ctx_saved <= 1'b0;
      pending_sleep <= 1'b0;
      circuit_mode <= `RBMC_MODE_IDLE_RC;
      retention_select <= 3'b000;
      power_down <= 1'b0;
      context_save <= 1'b0;
      context_restore <= 1'b0;
      mem_we <= 1'b0;
      mem_wa <= 8'h00;
      mem_wd <= 8'h00;
      tx_code <= 8'h00;
      tx_count <= 16'h0000;
      tx_start <= 1'b0;
      uart_tx_valid <= 1'b0;
      uart_tx_data <= 8'h00;
      fetch_uart_pend <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      tx_start <= 1'b0;
      context_save <= 1'b0;
      context_restore <= 1'b0;
      if (uart_tx_valid && uart_tx_ready) begin
        uart_tx_valid <= 1'b0;
      end
      // UART fetch: stream counted bytes, one read latency per byte
      if (fetch_uart_pend && !uart_tx_valid) begin
        uart_tx_valid <= 1'b1;
        uart_tx_data <= mem_rd;
        ptr <= ptr + 8'h01;
        uart_cnt <= uart_cnt - 8'h01;
        if (uart_cnt == 8'h01) begin
          fetch_uart_pend <= 1'b0;
          st <= S_IGN;
        end
      end
      if (circuit_mode == `RBMC_MODE_SLEEP) begin
        if (cs_rise || rtc_wake) begin
          circuit_mode <= `RBMC_MODE_IDLE_RC;
          power_down <= 1'b0;
          context_restore <= ctx_saved && retention_select[`RBMC_RET_DATA_RAM];
        end
      end else if (cs_rise) begin
        // Frame end commits a pending SPI low-power command
        if (pending_sleep) begin
          circuit_mode <= `RBMC_MODE_SLEEP;
          power_down <= 1'b1;
        end
        pending_sleep <= 1'b0;
        st <= S_OPC;
      end else if (tx_st == T_PLL) begin
        circuit_mode <= `RBMC_MODE_SYNTH;
      end else if (tx_st == T_RAMP) begin
        circuit_mode <= `RBMC_MODE_TX;
      end
      // A time-out may strike before the mode reached transmit
      if (timeout_evt || (tx_st == T_IDLE && circuit_mode == `RBMC_MODE_TX)) begin
        circuit_mode <= `RBMC_MODE_IDLE_RC;
      end
      if (byte_ok && circuit_mode != `RBMC_MODE_SLEEP) begin
        case (st)
          S_OPC: begin
            opcode <= byte_val;
            par_idx <= 3'd0;
            if (byte_val == `RBMC_OP_CTXSAVE) begin
              ctx_saved <= 1'b1;
              context_save <= 1'b1;
              cmd_status <= `RBMC_CST_OK;
              st <= S_IGN;
            end else if (byte_val == `RBMC_OP_SYNTH) begin
              circuit_mode <= `RBMC_MODE_SYNTH;
              cmd_status <= `RBMC_CST_OK;
              st <= S_IGN;
            end else if (byte_val == `RBMC_OP_STATUS) begin
              st <= S_IGN;
              if (byte_uart) begin
                uart_tx_valid <= 1'b1;
                uart_tx_data <= status_byte;
              end
            end else if (param_need(byte_val) == 3'd0) begin
              cmd_status <= `RBMC_CST_ERROR;
              st <= S_IGN;
            end else if (byte_uart && byte_val != `RBMC_OP_STORE && byte_val != `RBMC_OP_FETCH
                         && byte_val != `RBMC_OP_LOWPWR) begin
              st <= S_LEN;
            end else begin
              st <= S_PAR;
            end
          end
          S_LEN: begin
            st <= (byte_val[2:0] == param_need(opcode)) ? S_PAR : S_IGN;
            if (byte_val[2:0] != param_need(opcode)) begin
              cmd_status <= `RBMC_CST_ERROR;
            end
          end
          S_PAR: begin
            par_idx <= par_idx + 3'd1;
            if (par_idx == 3'd0) begin
              par0 <= byte_val;
            end
            if (par_idx == 3'd1) begin
              par1 <= byte_val;
            end
            if (par_idx == 3'd0 && (opcode == `RBMC_OP_STORE || opcode == `RBMC_OP_FETCH)) begin
              ptr <= byte_val;
              par_idx <= 3'd1;
              st <= byte_uart ? S_LEN : S_DATA;
              if (byte_uart) begin
                st <= S_DATA;
                par_idx <= 3'd3;
              end
            end else if (par_idx + 3'd1 == param_need(opcode)) begin
              st <= S_IGN;
              cmd_status <= `RBMC_CST_OK;
              case (opcode)
                `RBMC_OP_IDLE: begin
                  circuit_mode <= byte_val[0] ? `RBMC_MODE_IDLE_XTAL : `RBMC_MODE_IDLE_RC;
                end
                `RBMC_OP_LOWPWR: begin
                  if (is_idle(circuit_mode)) begin
                    retention_select <= byte_val[2:0];
                    if (byte_uart) begin
                      circuit_mode <= `RBMC_MODE_SLEEP;
                      power_down <= 1'b1;
                    end else begin
                      pending_sleep <= 1'b1;
                    end
                  end else begin
                    cmd_status <= `RBMC_CST_FAIL;
                  end
                end
                `RBMC_OP_TX: begin
                  tx_code <= par0;
                  tx_count <= {par1, byte_val};
                  tx_start <= 1'b1;
                end
                default: begin
                  cmd_status <= `RBMC_CST_ERROR;
                end
              endcase
            end
          end
          S_DATA: begin
            if (par_idx == 3'd3) begin
              // UART byte count
              uart_cnt <= byte_val;
              par_idx <= 3'd4;
              if (opcode == `RBMC_OP_FETCH && byte_val != 8'h00) begin
                fetch_uart_pend <= 1'b1;
              end
              if (byte_val == 8'h00) begin
                st <= S_IGN;
              end
            end else if (opcode == `RBMC_OP_STORE) begin
              mem_we <= 1'b1;
              mem_wa <= ptr;
              mem_wd <= byte_val;
              ptr <= ptr + 8'h01;
              if (par_idx == 3'd4) begin
                uart_cnt <= uart_cnt - 8'h01;
                if (uart_cnt == 8'h01) begin
                  st <= S_IGN;
                end
              end
            end else if (par_idx == 3'd1) begin
              par_idx <= 3'd2; // dummy byte consumed
            end else if (par_idx == 3'd2) begin
              ptr <= ptr + 8'h01;
            end
          end
          default: begin
            st <= S_IGN;
          end
        endcase
      end
      if (st == S_IGN && byte_uart && !fetch_uart_pend) begin
        st <= S_OPC;
      end
    end
  end

  // Transmit sequence
  always @(posedge mclk) begin
    if (reset) begin
      tx_st <= T_IDLE;
      phase_cnt <= 8'h00;
      osc_on <= 1'b0;
      pll_on <= 1'b0;
      pa_on <= 1'b0;
      pa_ramp <= 1'b0;
      packet_start <= 1'b0;
      transmit_complete_evt <= 1'b0;
      timeout_evt <= 1'b0;
      timer_stop <= 1'b0;
    end else begin
      packet_start <= 1'b0;
      transmit_complete_evt <= 1'b0;
      timeout_evt <= 1'b0;
      timer_stop <= 1'b0;
      phase_cnt <= phase_cnt + 8'h01;
      if (timer_expired && tx_st != T_IDLE) begin
        timeout_evt <= 1'b1;
        tx_st <= T_IDLE;
        osc_on <= 1'b0;
        pll_on <= 1'b0;
        pa_on <= 1'b0;
        pa_ramp <= 1'b0;
      end else begin
        case (tx_st)
          T_IDLE: begin
            if (tx_start) begin
              tx_st <= T_OSC;
              osc_on <= 1'b1;
              phase_cnt <= 8'h00;
            end
          end
          T_OSC: begin
            if (phase_cnt == PHASE[7:0]) begin
              tx_st <= T_PLL;
              pll_on <= 1'b1;
              phase_cnt <= 8'h00;
            end
          end
          T_PLL: begin
            if (phase_cnt == PHASE[7:0]) begin
              tx_st <= T_RAMP;
              pa_on <= 1'b1;
              pa_ramp <= 1'b1;
              phase_cnt <= 8'h00;
            end
          end
          T_RAMP: begin
            if (phase_cnt == PHASE[7:0]) begin
              tx_st <= T_SEND;
              packet_start <= 1'b1;
            end
          end
          T_SEND: begin
            if (packet_sent) begin
              tx_st <= T_DOWN;
              pa_ramp <= 1'b0;
              timer_stop <= 1'b1;
              phase_cnt <= 8'h00;
            end
          end
          T_DOWN: begin
            if (phase_cnt == PHASE[7:0]) begin
              tx_st <= T_IDLE;
              pa_on <= 1'b0;
              pll_on <= 1'b0;
              osc_on <= 1'b0;
              transmit_complete_evt <= 1'b1;
            end
          end
          default: begin
            tx_st <= T_IDLE;
          end
        endcase
      end
    end
  end
endmodule // rbmc_cmd_decoder

// >>> verilog/rbmc_defs.vh
`ifndef RBMC_DEFS_VH
`define RBMC_DEFS_VH
// Opcodes
`define RBMC_OP_STORE 8'h1A
`define RBMC_OP_FETCH 8'h1B
`define RBMC_OP_LOWPWR 8'h84
`define RBMC_OP_IDLE 8'h80
`define RBMC_OP_SYNTH 8'hC1
`define RBMC_OP_TX 8'h83
`define RBMC_OP_STATUS 8'hC0
`define RBMC_OP_CTXSAVE 8'hD5
`define RBMC_UART_LEN_IDLE 8'h01
`define RBMC_UART_LEN_TX 8'h03
// Circuit mode codes (status bits 7:5)
`define RBMC_MODE_SLEEP 3'h0
`define RBMC_MODE_IDLE_RC 3'h2
`define RBMC_MODE_IDLE_XTAL 3'h3
`define RBMC_MODE_SYNTH 3'h4
`define RBMC_MODE_TX 3'h6
// Command status codes (status bits 4:2)
`define RBMC_CST_OK 3'h1
`define RBMC_CST_TIMEOUT 3'h3
`define RBMC_CST_ERROR 3'h4
`define RBMC_CST_FAIL 3'h5
`define RBMC_CST_TRANSMIT_COMPLETE_EVT 3'h6
// Retention bits
`define RBMC_RET_DATA_RAM 0
`define RBMC_RET_BUFFER 1
`define RBMC_RET_INSTR_RAM 2
// Time-out steps in ns, cycles at 100 MHz
`define RBMC_CLK_NS 10
`define RBMC_STEP0_NS 15625
`define RBMC_STEP1_NS 62500
`define RBMC_STEP2_NS 1000000
`define RBMC_STEP3_NS 4000000
`define RBMC_STEP0_CYC (`RBMC_STEP0_NS / `RBMC_CLK_NS)
`define RBMC_STEP1_CYC (`RBMC_STEP1_NS / `RBMC_CLK_NS)
`define RBMC_STEP2_CYC (`RBMC_STEP2_NS / `RBMC_CLK_NS)
`define RBMC_STEP3_CYC (`RBMC_STEP3_NS / `RBMC_CLK_NS)
// Transmit sequencing phase terminal count; each timed phase lasts this plus one cycle
`define RBMC_PHASE_CYC 8
`endif

// >>> verilog/rbmc_buffer_mem.v
`timescale 1ns/1ps
module rbmc_buffer_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock
  input wire mclk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // rbmc_buffer_mem

// >>> verilog/rbmc_tx_timer.v
`timescale 1ns/1ps
`include "rbmc_defs.vh"
module rbmc_tx_timer #(
  parameter STEP0 = `RBMC_STEP0_CYC,
  parameter STEP1 = `RBMC_STEP1_CYC,
  parameter STEP2 = `RBMC_STEP2_CYC,
  parameter STEP3 = `RBMC_STEP3_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Control
  input wire start,
  input wire stop,
  input wire [1:0] timeout_step_code,
  input wire [15:0] timeout_step_count,
  // Result
  output reg expired
);
  reg [21:0] prescale;
  reg [21:0] step_len;
  reg [15:0] steps_left;
  reg armed;
  wire step_tick;

  assign step_tick = armed && (prescale == 22'h00_0000);

  always @(posedge mclk) begin
    if (reset) begin
      prescale <= 22'h00_0000;
      step_len <= 22'h00_0000;
      steps_left <= 16'h0000;
      armed <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        case (timeout_step_code)
          2'd0: step_len <= STEP0[21:0] - 22'h00_0001;
          2'd1: step_len <= STEP1[21:0] - 22'h00_0001;
          2'd2: step_len <= STEP2[21:0] - 22'h00_0001;
          default: step_len <= STEP3[21:0] - 22'h00_0001;
        endcase
        case (timeout_step_code)
          2'd0: prescale <= STEP0[21:0] - 22'h00_0001;
          2'd1: prescale <= STEP1[21:0] - 22'h00_0001;
          2'd2: prescale <= STEP2[21:0] - 22'h00_0001;
          default: prescale <= STEP3[21:0] - 22'h00_0001;
        endcase
        steps_left <= timeout_step_count;
        armed <= (timeout_step_count != 16'h0000);
      end else if (stop) begin
        armed <= 1'b0;
      end else if (step_tick) begin
        prescale <= step_len;
        steps_left <= steps_left - 16'h0001;
        if (steps_left == 16'h0001) begin
          armed <= 1'b0;
          expired <= 1'b1;
        end
      end else if (armed) begin
        prescale <= prescale - 22'h00_0001;
      end
    end
  end
endmodule // rbmc_tx_timer

// >>> sim/rbmc_host_model.sv
`timescale 1ns/1ps
module rbmc_host_model (
  // SPI lines
  output reg spi_sck,
  output reg chip_select_n,
  output reg spi_mosi,
  input wire spi_miso
);
  initial begin
    spi_sck = 1'b0;
    chip_select_n = 1'b1;
    spi_mosi = 1'b1;
  end
  task sel;
    begin
      chip_select_n = 1'b0;
      #200;
    end
  endtask
  task desel;
    begin
      #100;
      chip_select_n = 1'b1;
      #100;
    end
  endtask
  // Mode 0, clock idles low between frames
  task xfer(input [7:0] b, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        spi_mosi = b[i];
        #62.5;
        spi_sck = 1'b1;
        r[i] = spi_miso;
        #62.5;
        spi_sck = 1'b0;
      end
      // Undriven line must not look like held data
      spi_mosi = ~spi_mosi;
      #100;
    end
  endtask
endmodule // rbmc_host_model

// >>> sim/rbmc_cmd_decoder_monitor.sv
`timescale 1ns/1ps
module rbmc_cmd_decoder_monitor (
  // Clock, reset, wake
  input wire mclk,
  input wire reset,
  input wire rtc_wake,
  // Radio side
  input wire [2:0] circuit_mode,
  input wire osc_on,
  input wire pll_on,
  input wire pa_on,
  input wire packet_start,
  input wire power_down,
  input wire transmit_complete_evt,
  input wire timeout_evt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  reset_idle_a: assert property ($fell(reset) |-> circuit_mode == 3'h2) else $error("not idle");
  osc_pll_a: assert property (pll_on |-> osc_on) else $error("pll without osc");
  pll_pa_a: assert property (pa_on |-> pll_on) else $error("pa without pll");
  send_pa_a: assert property (packet_start |-> pa_on) else $error("send without pa");
  synth_tx_a: assert property ($rose(circuit_mode == 3'h6) |-> $past(circuit_mode) == 3'h4)
    else $error("tx not via synth");
  done_idle_a: assert property (transmit_complete_evt |-> ##[0:2] (circuit_mode == 3'h2 && !pa_on))
    else $error("done not idle");
  timeout_idle_a: assert property (timeout_evt |-> ##[0:2] circuit_mode == 3'h2)
    else $error("timeout not idle");
  event_once_a: assert property (transmit_complete_evt |-> !timeout_evt ##1 !transmit_complete_evt)
    else $error("event clash");
  sleep_off_a: assert property ($rose(circuit_mode == 3'h0) |-> ##[0:1] (power_down && !osc_on))
    else $error("sleep not off");
  rtc_wake_a: assert property (rtc_wake && circuit_mode == 3'h0 |-> ##[1:4] circuit_mode == 3'h2)
    else $error("no rtc wake");
  cover property (transmit_complete_evt);
  cover property (timeout_evt);
  cover property ($rose(power_down));
endmodule // rbmc_cmd_decoder_monitor
bind rbmc_cmd_decoder rbmc_cmd_decoder_monitor mon (
  .mclk(mclk), .reset(reset), .rtc_wake(rtc_wake), .circuit_mode(circuit_mode),
  .osc_on(osc_on), .pll_on(pll_on), .pa_on(pa_on), .packet_start(packet_start),
  .power_down(power_down), .transmit_complete_evt(transmit_complete_evt), .timeout_evt(timeout_evt)
);

// >>> sim/radio_buffer_and_mode_commands_tb.sv
`timescale 1ns/1ps
module radio_buffer_and_mode_commands_tb;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg uart_rx_valid = 1'b0;
  reg [7:0] uart_rx_data = 8'h00;
  reg packet_sent = 1'b0;
  reg rtc_wake = 1'b0;
  reg osc_q = 1'b0;
  reg tx_rdy = 1'b1;
  integer cyc = 0, osc_cyc = 0, to_cyc = 0, rst_n = 0, to_n = 0, ps_n = 0, ctx_n = 0, m;
  wire spi_sck, chip_select_n, spi_mosi, spi_miso, uart_tx_valid, osc_on, pll_on, pa_on, pa_ramp;
  wire packet_start, power_down, context_save, context_restore, transmit_complete_evt, timeout_evt;
  wire [7:0] uart_tx_data;
  wire [2:0] circuit_mode, retention_select;
  integer errors = 0, checks = 0, i, n, t, e;
  reg [7:0] r, off;
  reg [7:0] cb [0:3];
  reg [7:0] bufm [0:255];
  rbmc_cmd_decoder #(.STEP0(2), .STEP1(3), .STEP2(4), .STEP3(5)) uut (
    .mclk(mclk), .reset(reset), .spi_sck(spi_sck), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data),
    .uart_tx_valid(uart_tx_valid), .uart_tx_data(uart_tx_data), .uart_tx_ready(tx_rdy),
    .packet_sent(packet_sent), .rtc_wake(rtc_wake), .circuit_mode(circuit_mode), .osc_on(osc_on),
    .pll_on(pll_on), .pa_on(pa_on), .pa_ramp(pa_ramp), .packet_start(packet_start),
    .retention_select(retention_select), .power_down(power_down), .context_save(context_save),
    .context_restore(context_restore), .transmit_complete_evt(transmit_complete_evt), .timeout_evt(timeout_evt)
  );
  rbmc_host_model host (.spi_sck(spi_sck), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Events are counted here so pulses during a frame are not missed
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    osc_q <= osc_on;
    if (osc_on === 1'b1 && osc_q !== 1'b1) osc_cyc <= cyc;
    if (context_restore === 1'b1) rst_n <= rst_n + 1;
    if (context_save === 1'b1) ctx_n <= ctx_n + 1;
    if (packet_start === 1'b1) ps_n <= ps_n + 1;
    if (timeout_evt === 1'b1) begin
      to_n <= to_n + 1;
      to_cyc <= cyc;
    end
  end
  task test_done;
    begin
      if (errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [15:0] x, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        errors = errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task lim(input ok);
    begin
      chk("wait", 1, ok);
      if (!ok) test_done;
    end
  endtask
  task spi(input integer nb);
    integer k;
    begin
      host.sel;
      for (k = 0; k < nb; k = k + 1) host.xfer(cb[k], r);
      host.desel;
      @(negedge mclk);
    end
  endtask
  task ub(input [7:0] b);
    begin
      @(negedge mclk);
      uart_rx_valid = 1'b1;
      uart_rx_data = b;
      @(negedge mclk);
      uart_rx_valid = 1'b0;
    end
  endtask
  initial begin
    i = $urandom(50);
    repeat (16) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    repeat (4) @(negedge mclk);
    chk("mode", 3'h2, circuit_mode);
    // Offset near the top so the pointer must wrap
    off = 8'hFD;
    host.sel;
    host.xfer(8'h1A, r);
    host.xfer(off, r);
    for (i = 0; i < 6; i = i + 1) begin
      cb[0] = $urandom;
      bufm[(off + i) % 256] = cb[0];
      host.xfer(cb[0], r);
      chk("status", 3'h2, r[7:5]);
    end
    host.desel;
    host.sel;
    host.xfer(8'h1B, r);
    host.xfer(off, r);
    host.xfer(8'h00, r);
    for (i = 0; i < 6; i = i + 1) begin
      host.xfer(8'h00, r);
      chk("spi_data", bufm[(off + i) % 256], r);
    end
    host.desel;
    ub(8'h1B);
    ub(off + 8'h02);
    ub(8'h04);
    n = 0;
    for (t = 0; t < 400 && n < 4; t = t + 1) begin
      @(negedge mclk);
      tx_rdy = $urandom % 2;
      if (uart_tx_valid === 1'b1 && tx_rdy) begin
        chk("uart_data", bufm[(off + 2 + n) % 256], uart_tx_data);
        n = n + 1;
      end
    end
    lim(n == 4);
    @(negedge mclk) tx_rdy = 1'b1;
    cb[0] = 8'h80;
    cb[1] = 8'h01;
    spi(2);
    chk("mode", 3'h3, circuit_mode);
    ub(8'h80);
    ub(8'h01);
    ub(8'h00);
    repeat (4) @(negedge mclk);
    chk("mode", 3'h2, circuit_mode);
    cb[0] = 8'hC1;
    spi(1);
    chk("mode", 3'h4, circuit_mode);
    cb[0] = 8'h84;
    spi(2);
    chk("mode", 3'h4, circuit_mode);
    cb[0] = 8'h80;
    cb[1] = 8'h00;
    spi(2);
    cb[0] = 8'hD5;
    spi(1);
    chk("ctx_save", 1, ctx_n);
    cb[0] = 8'h84;
    cb[1] = $urandom;
    cb[1][0] = 1'b1;
    spi(2);
    chk("power_down", 1, power_down);
    chk("retain", cb[1][2:0], retention_select);
    m = rst_n;
    spi(0);
    chk("mode", 3'h2, circuit_mode);
    chk("restore", 1, rst_n - m);
    cb[1][0] = 1'b0;
    spi(2);
    chk("retain", cb[1][2:0], retention_select);
    m = rst_n;
    rtc_wake = 1'b1;
    @(negedge mclk) rtc_wake = 1'b0;
    repeat (8) @(negedge mclk);
    chk("mode", 3'h2, circuit_mode);
    chk("restore", 0, rst_n - m);
    chk("no_event", 0, to_n);
    // No count, then a count too long to expire
    for (i = 0; i < 2; i = i + 1) begin
      cb[0] = 8'h83;
      cb[1] = 8'h03;
      cb[2] = i ? 8'hFF : 8'h00;
      cb[3] = cb[2];
      n = ps_n;
      spi(4);
      for (t = 0; t < 200 && ps_n == n; t = t + 1) @(negedge mclk);
      lim(t < 200);
      chk("mode", 3'h6, circuit_mode);
      chk("pa_ramp", 1, pa_ramp);
      packet_sent = 1'b1;
      @(negedge mclk) packet_sent = 1'b0;
      for (t = 0; t < 100 && transmit_complete_evt !== 1'b1; t = t + 1) @(negedge mclk);
      lim(t < 100);
      @(negedge mclk);
      chk("mode", 3'h2, circuit_mode);
    end
    chk("timeout", 0, to_n);
    cb[1] = $urandom % 4;
    cb[2] = 8'h00;
    cb[3] = 10 + $urandom % 20;
    e = (cb[1] + 2) * cb[3];
    spi(4);
    for (t = 0; t < 600 && to_n == 0; t = t + 1) @(negedge mclk);
    lim(t < 600);
    // Measured from oscillator start, which coincides with timer start
    chk("timeout_win", 1, to_cyc - osc_cyc >= e && to_cyc - osc_cyc <= e + 4);
    repeat (3) @(negedge mclk);
    chk("mode", 3'h2, circuit_mode);
    test_done;
  end
endmodule // radio_buffer_and_mode_commands_tb
